// File: design/rbb_map.svh
// Register map, field positions and reset values of the receive byte-buffer control
`ifndef RBB_MAP_SVH
`define RBB_MAP_SVH
`define RBB_ADDR_CTRL 6'h06
`define RBB_ADDR_INTEN 6'h07
`define RBB_ADDR_STAT 6'h08
`define RBB_ADDR_DATA_A 6'h09
`define RBB_ADDR_DATA_B 6'h0B
`define RBB_CTRL_RST 4'h3
`define RBB_INTEN_RST 8'h00
`define RBB_CTRL_MODE 3
`define RBB_GAP_MSB 2
`define RBB_CH_STRIDE 4
`define RBB_EN_FULL 0
`define RBB_EN_EOF 1
`define RBB_EN_OVF 2
`define RBB_EN_UNF 3
`define RBB_SPI_WR_BIT 7
`define RBB_SPI_ADDR_MSB 5
`define RBB_LAST_BIT 4'h7
`define RBB_SPI_LAST 3'h7
`endif

// File: design/rbb_pkg.sv
// Types shared by the receive byte-buffer control modules
package rbb_pkg;
   typedef logic [7:0] rbb_byte_t;
   typedef logic [2:0] rbb_gap_t;
   typedef enum logic [1:0] {SPI_CMD, SPI_DATA, SPI_DONE} rbb_spi_e;
endpackage

// File: design/rbb_rx_chan.sv
// One receive channel: byte assembly and end-of-frame gap detection
`timescale 1ns/1ps
`default_nettype none
`include "rbb_map.svh"
module rbb_rx_chan (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Control
   input wire logic i_enable,
   input wire rbb_pkg::rbb_gap_t i_gap_len,
   // Correlator bit stream
   input wire logic i_bit_stb,
   input wire logic i_bit_valid,
   input wire logic i_bit_data,
   // Transfer to data register
   output logic o_push,
   output logic o_eof,
   output logic o_whole,
   output rbb_pkg::rbb_byte_t o_byte
);
   import rbb_pkg::*;
   rbb_byte_t shift_r;
   logic [3:0] cnt_r;
   logic [3:0] gap_r;
   logic seen_r;
   wire rbb_byte_t shift_nxt = {shift_r[6:0], i_bit_data};
   wire byte_done = i_bit_stb & i_bit_valid & (cnt_r == `RBB_LAST_BIT);
   // Gap counts earlier invalid bits, so equality means the count now exceeds it
   wire eof_hit = i_bit_stb & ~i_bit_valid & seen_r & (gap_r == {1'b0, i_gap_len});
   wire partial = eof_hit & (cnt_r != 4'h0);

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         shift_r <= 8'h00;
         cnt_r <= 4'h0;
         gap_r <= 4'h0;
         seen_r <= 1'b0;
         o_push <= 1'b0;
         o_eof <= 1'b0;
         o_whole <= 1'b0;
         o_byte <= 8'h00;
      end else if (!i_enable) begin
         // Bit-serial mode: the buffer path stays idle
         shift_r <= 8'h00;
         cnt_r <= 4'h0;
         gap_r <= 4'h0;
         seen_r <= 1'b0;
         o_push <= 1'b0;
         o_eof <= 1'b0;
      end else begin
         o_push <= byte_done | partial;
         o_eof <= eof_hit;
         if (byte_done) begin
            o_byte <= shift_nxt;
            o_whole <= 1'b1;
         end else if (partial) begin
            o_byte <= shift_r;
            o_whole <= 1'b0;
         end
         // Cleared per unit so a partial byte carries no stale upper bits
         if (i_bit_stb && i_bit_valid) begin
            shift_r <= byte_done ? 8'h00 : shift_nxt;
            cnt_r <= byte_done ? 4'h0 : cnt_r + 4'h1;
            seen_r <= 1'b1;
            gap_r <= 4'h0;
         end else if (eof_hit) begin
            shift_r <= 8'h00;
            cnt_r <= 4'h0;
            seen_r <= 1'b0;
            gap_r <= 4'h0;
         end else if (i_bit_stb && seen_r) begin
            gap_r <= gap_r + 4'h1;
         end
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   property p_gap_zero;
      i_enable && i_bit_stb && !i_bit_valid && seen_r && (i_gap_len == 3'h0) |=> o_eof;
   endproperty
   a_gap_zero: assert property (p_gap_zero) else $error("No end of frame at first invalid bit");
   property p_eof_after_gap;
      o_eof |-> $past(gap_r) == {1'b0, $past(i_gap_len)} && !$past(i_bit_valid);
   endproperty
   a_eof_after_gap: assert property (p_eof_after_gap) else $error("End of frame before gap elapsed");
endmodule // rbb_rx_chan
`default_nettype wire

// File: design/rbb_rx_ctrl.sv
// Receive byte-buffer control: register port, channel flags and interrupt request
// Overview of operation
// - Mode bit picks byte buffer or serial pins
// - Gap field sets invalid bit times for EOF
// - After valid bit, EOF when gap exceeded
// - EOF moves pending data, raises event
// - Gap zero: EOF at first invalid bit
// - Enable bit 7: channel B underflow
// - Enable bit 6: channel B overflow
// - Enable bit 5: channel B end of frame
// - Status read clears pending EOF
// - Enable bit 4: channel B full
// - Low nibble holds channel A enables
// - Full flagged on every data transfer
`timescale 1ns/1ps
`default_nettype none
`include "rbb_map.svh"
module rbb_rx_ctrl (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Serial register port
   input wire logic i_spi_sclk,
   input wire logic i_spi_ss_b,
   input wire logic i_spi_mosi,
   output logic o_spi_miso,
   output logic o_spi_miso_oe_b,
   // Correlator bit streams, index 0 is channel A
   input wire logic [1:0] i_bit_stb,
   input wire logic [1:0] i_bit_valid,
   input wire logic [1:0] i_bit_data,
   // Bit-serial pins
   output logic o_serial_data_pin,
   output logic o_serial_data_valid_pin,
   // Interrupt request
   output logic o_irq
);
   import rbb_pkg::*;
   logic [2:0] in_s1_r;
   logic [2:0] in_s2_r;
   logic sclk_d_r;
   logic [2:0] bcnt_r;
   rbb_byte_t rx_r;
   rbb_byte_t tx_r;
   logic wr_r;
   logic [5:0] addr_r;
   rbb_spi_e st_r;
   logic [3:0] ctrl_r;
   rbb_byte_t inten_r;
   logic [1:0] full_r;
   logic [1:0] eof_r;
   logic [1:0] ovf_r;
   logic [1:0] unf_r;
   logic [1:0] valid_r;
   rbb_byte_t data_r [2];
   logic [1:0] push;
   logic [1:0] eof_ev;
   logic [1:0] whole;
   rbb_byte_t ch_byte [2];
   logic [7:0] stat;
   logic [7:0] pend;
   logic [1:0] rd_data;

   // Pin inputs, first stage read only by the second
   wire ss_b = in_s2_r[1];
   wire sclk_rise = in_s2_r[2] & ~sclk_d_r & ~ss_b;
   wire sclk_fall = ~in_s2_r[2] & sclk_d_r & ~ss_b;
   wire rbb_byte_t rx_nxt = {rx_r[6:0], in_s2_r[0]};
   wire byte_end = sclk_rise & (bcnt_r == `RBB_SPI_LAST);
   wire rd_stb = byte_end & (st_r == SPI_CMD) & ~rx_nxt[`RBB_SPI_WR_BIT];
   wire [5:0] rd_addr = rx_nxt[`RBB_SPI_ADDR_MSB:0];
   wire wr_stb = byte_end & (st_r == SPI_DATA) & wr_r;
   wire rd_stat = rd_stb & (rd_addr == `RBB_ADDR_STAT);
   wire mode_buf = ctrl_r[`RBB_CTRL_MODE];
   rbb_byte_t rdata;

   // Reserved control bits read back as zero
   always_comb begin
      if (rd_addr == `RBB_ADDR_CTRL) begin
         rdata = {4'h0, ctrl_r};
      end else if (rd_addr == `RBB_ADDR_INTEN) begin
         rdata = inten_r;
      end else if (rd_addr == `RBB_ADDR_STAT) begin
         rdata = stat;
      end else if (rd_addr == `RBB_ADDR_DATA_A) begin
         rdata = data_r[0];
      end else if (rd_addr == `RBB_ADDR_DATA_B) begin
         rdata = data_r[1];
      end else begin
         rdata = 8'h00;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         in_s1_r <= 3'h2;
         in_s2_r <= 3'h2;
         sclk_d_r <= 1'b0;
      end else begin
         in_s1_r <= {i_spi_sclk, i_spi_ss_b, i_spi_mosi};
         in_s2_r <= in_s1_r;
         sclk_d_r <= in_s2_r[2];
      end
   end

   // One command byte and one data byte per select; extra bytes ignored
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         bcnt_r <= 3'h0;
         rx_r <= 8'h00;
         tx_r <= 8'h00;
         wr_r <= 1'b0;
         addr_r <= 6'h00;
         st_r <= SPI_CMD;
         o_spi_miso <= 1'b0;
         o_spi_miso_oe_b <= 1'b1;
      end else if (ss_b) begin
         bcnt_r <= 3'h0;
         st_r <= SPI_CMD;
         o_spi_miso_oe_b <= 1'b1;
      end else begin
         o_spi_miso_oe_b <= 1'b0;
         if (sclk_rise) begin
            rx_r <= rx_nxt;
            bcnt_r <= bcnt_r + 3'h1;
            tx_r <= rd_stb ? rdata : {tx_r[6:0], 1'b0};
         end
         if (sclk_fall) begin
            o_spi_miso <= tx_r[7];
         end
         if (byte_end) begin
            case (st_r)
               SPI_CMD: begin
                  wr_r <= rx_nxt[`RBB_SPI_WR_BIT];
                  addr_r <= rd_addr;
                  st_r <= SPI_DATA;
               end
               SPI_DATA: st_r <= SPI_DONE;
               default: st_r <= SPI_DONE;
            endcase
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_r <= `RBB_CTRL_RST;
         inten_r <= `RBB_INTEN_RST;
      end else if (wr_stb && addr_r == `RBB_ADDR_CTRL) begin
         ctrl_r <= rx_nxt[`RBB_CTRL_MODE:0];
      end else if (wr_stb && addr_r == `RBB_ADDR_INTEN) begin
         inten_r <= rx_nxt;
      end
   end

   genvar g;
   for (g = 0; g < 2; g++) begin : g_ch
      localparam logic [5:0] DATA_ADDR = (g == 0) ? `RBB_ADDR_DATA_A : `RBB_ADDR_DATA_B;
      rbb_rx_chan u_chan (
         .i_clk(i_clk),
         .i_rst_b(i_rst_b),
         .i_enable(mode_buf),
         .i_gap_len(ctrl_r[`RBB_GAP_MSB:0]),
         .i_bit_stb(i_bit_stb[g]),
         .i_bit_valid(i_bit_valid[g]),
         .i_bit_data(i_bit_data[g]),
         .o_push(push[g]),
         .o_eof(eof_ev[g]),
         .o_whole(whole[g]),
         .o_byte(ch_byte[g])
      );
      assign rd_data[g] = rd_stb & (rd_addr == DATA_ADDR);
      assign stat[`RBB_CH_STRIDE*g +: `RBB_CH_STRIDE] = {valid_r[g], ovf_r[g] | unf_r[g], eof_r[g], full_r[g]};
      assign pend[`RBB_CH_STRIDE*g +: `RBB_CH_STRIDE] = {unf_r[g], ovf_r[g], eof_r[g], full_r[g]};
      // New events win over a clearing read in the same cycle
      always_ff @(posedge i_clk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            full_r[g] <= 1'b0;
            eof_r[g] <= 1'b0;
            ovf_r[g] <= 1'b0;
            unf_r[g] <= 1'b0;
            valid_r[g] <= 1'b0;
            data_r[g] <= 8'h00;
         end else begin
            full_r[g] <= push[g] | (full_r[g] & ~rd_data[g]);
            eof_r[g] <= eof_ev[g] | (eof_r[g] & ~rd_stat);
            ovf_r[g] <= (push[g] & full_r[g] & ~rd_data[g]) | (ovf_r[g] & ~rd_stat);
            unf_r[g] <= (rd_data[g] & ~full_r[g]) | (unf_r[g] & ~rd_stat);
            if (push[g]) begin
               data_r[g] <= ch_byte[g];
               valid_r[g] <= whole[g];
            end
         end
      end
   end

   // Serial pins carry channel A only while the byte buffer is off
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_serial_data_pin <= 1'b0;
         o_serial_data_valid_pin <= 1'b0;
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(pend & inten_r);
         if (mode_buf) begin
            o_serial_data_valid_pin <= 1'b0;
         end else if (i_bit_stb[0]) begin
            o_serial_data_pin <= i_bit_data[0];
            o_serial_data_valid_pin <= i_bit_valid[0];
         end
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   property p_irq_follows;
      (|(pend & inten_r)) |=> o_irq;
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("Enabled condition without request");
   property p_irq_quiet;
      !(|(pend & inten_r)) |=> !o_irq;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("Request without enabled condition");
   property p_full_a;
      push[0] && inten_r[`RBB_EN_FULL] |=> ##1 o_irq;
   endproperty
   a_full_a: assert property (p_full_a) else $error("Full A enable ignored");
   property p_full_b;
      push[1] && inten_r[`RBB_CH_STRIDE + `RBB_EN_FULL] |=> full_r[1] ##1 o_irq;
   endproperty
   a_full_b: assert property (p_full_b) else $error("Full B enable ignored");
   property p_eof_b;
      eof_ev[1] && inten_r[`RBB_CH_STRIDE + `RBB_EN_EOF] |=> eof_r[1] ##1 o_irq;
   endproperty
   a_eof_b: assert property (p_eof_b) else $error("EOF B not raised");
   property p_ovf_b;
      push[1] && full_r[1] && !rd_data[1] |=> ovf_r[1] && stat[6];
   endproperty
   a_ovf_b: assert property (p_ovf_b) else $error("Overflow B missed");
   property p_unf_b;
      rd_data[1] && !full_r[1] |=> unf_r[1];
   endproperty
   a_unf_b: assert property (p_unf_b) else $error("Underflow B missed");
   property p_stat_clear;
      rd_stat && eof_ev == 2'b00 |=> eof_r == 2'b00;
   endproperty
   a_stat_clear: assert property (p_stat_clear) else $error("Status read left EOF set");
   property p_mode_serial;
      mode_buf && $past(mode_buf) |-> !o_serial_data_valid_pin [*2];
   endproperty
   a_mode_serial: assert property (p_mode_serial) else $error("Serial pins active in buffer mode");
   property p_serial_idle;
      !$past(mode_buf) |-> push == 2'b00;
   endproperty
   a_serial_idle: assert property (p_serial_idle) else $error("Buffer push in bit-serial mode");
   property p_eof_push;
      eof_ev[1] && push[1] |=> full_r[1] && !stat[7];
   endproperty
   a_eof_push: assert property (p_eof_push) else $error("Partial byte at EOF not flagged full");
   c_eof: cover property (eof_ev[1] ##1 eof_r[1]);
   c_ovf: cover property (ovf_r[1]);
   c_write: cover property (wr_stb && addr_r == `RBB_ADDR_CTRL);
   c_irq: cover property (!o_irq ##1 o_irq);
endmodule // rbb_rx_ctrl
`default_nettype wire

// File: bench/rbb_host_model.sv
// Host model driving the serial register port
`timescale 1ns/1ps
`default_nettype none
module rbb_host_model (
   // Clock
   input wire logic i_clk,
   // Serial register port
   output logic o_sclk,
   output logic o_ss_b,
   output logic o_mosi,
   input wire logic i_miso
);
   import rbb_pkg::*;
   initial begin
      o_sclk = 1'b0;
      o_ss_b = 1'b1;
      o_mosi = 1'b0;
   end
   // Command then data byte, sent MSB first under one select
   task automatic xfer(input logic [15:0] tx, output rbb_byte_t rx);
      @(posedge i_clk);
      o_ss_b <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         o_mosi <= tx[i];
         repeat (4) @(posedge i_clk);
         o_sclk <= 1'b1;
         repeat (4) @(posedge i_clk);
         // Sampled just before the fall that moves it on
         if (i < 8) rx = {rx[6:0], i_miso};
         o_sclk <= 1'b0;
      end
      repeat (4) @(posedge i_clk);
      o_ss_b <= 1'b1;
      // Released line must not keep the last bit
      o_mosi <= ~o_mosi;
      repeat (6) @(posedge i_clk);
   endtask
endmodule // rbb_host_model
`default_nettype wire

// File: bench/tb_rx_byte_buffer_eof_irq_ctrl.sv
// Self-checking bench of the receive byte-buffer control
`timescale 1ns/1ps
`default_nettype none
`include "rbb_map.svh"
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin n_fail++; \
   $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module tb_rx_byte_buffer_eof_irq_ctrl;
   import rbb_pkg::*;
   logic i_clk, i_rst_b, sclk, ss_b, mosi, miso, sd, sv, irq, oe_b;
   logic oe_seen = 1'b0;
   logic [1:0] stb, vld, dat;
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;
   rbb_byte_t r;
   rbb_rx_ctrl dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_spi_sclk(sclk), .i_spi_ss_b(ss_b),
      .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe_b(oe_b), .i_bit_stb(stb), .i_bit_valid(vld),
      .i_bit_data(dat), .o_serial_data_pin(sd), .o_serial_data_valid_pin(sv), .o_irq(irq));
   rbb_host_model host_u (.i_clk(i_clk), .o_sclk(sclk), .o_ss_b(ss_b), .o_mosi(mosi), .i_miso(miso));
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc++;
      if (oe_b === 1'b0) oe_seen <= 1'b1;
      if (cyc == 60000) begin
         n_fail++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d failures %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [5:0] a, input rbb_byte_t d);
      rbb_byte_t x;
      host_u.xfer({2'b10, a, d}, x);
   endtask
   task automatic rd(input logic [5:0] a);
      host_u.xfer({2'b00, a, 8'h00}, r);
   endtask
   // Host keeps control bits 7:4 at zero and prefers byte mode
   task automatic mode(input logic m, input rbb_gap_t g);
      wr(`RBB_ADDR_CTRL, {4'h0, m, g});
   endtask
   task automatic bit_tx(input int ch, input logic v, input logic d);
      @(posedge i_clk);
      stb[ch] <= 1'b1;
      vld[ch] <= v;
      dat[ch] <= d;
      @(posedge i_clk);
      stb[ch] <= 1'b0;
      repeat (4) @(posedge i_clk);
   endtask
   task automatic byte_tx(input int ch, input rbb_byte_t b);
      for (int i = 7; i >= 0; i--) bit_tx(ch, 1'b1, b[i]);
   endtask
   task automatic t_reset();
      rd(`RBB_ADDR_CTRL);
      `CHK("ctrl rst", 8'h03, r)
      `CHK("oe used", 1'b1, oe_seen)
      `CHK("oe idle", 1'b1, oe_b)
      `CHK("irq rst", 1'b0, irq)
      rd(`RBB_ADDR_INTEN);
      `CHK("inten rst", 8'h00, r)
      rd(`RBB_ADDR_STAT);
      `CHK("stat rst", 8'h00, r)
      rd(6'h3E);
      `CHK("unmapped", 8'h00, r)
      $display("test reset done");
   endtask
   task automatic t_serial();
      bit_tx(0, 1'b1, 1'b1);
      `CHK("ser pins", 2'b11, {sd, sv})
      bit_tx(0, 1'b0, 1'b0);
      `CHK("ser pins", 2'b00, {sd, sv})
      $display("test serial done");
   endtask
   task automatic t_byte();
      mode(1'b1, 3'h3);
      rd(`RBB_ADDR_CTRL);
      `CHK("ctrl rb", 8'h0B, r)
      wr(`RBB_ADDR_INTEN, 8'h01);
      byte_tx(0, 8'hA5);
      `CHK("irq full A", 1'b1, irq)
      `CHK("valid pin", 1'b0, sv)
      rd(`RBB_ADDR_STAT);
      `CHK("stat A", 8'h09, r & 8'h0F)
      rd(`RBB_ADDR_DATA_A);
      `CHK("data A", 8'hA5, r)
      `CHK("irq clr", 1'b0, irq)
      $display("test byte done");
   endtask
   // Gap 0, mid and top value of the gap field
   task automatic t_eof();
      rbb_gap_t g;
      for (int k = 0; k < 3; k++) begin
         g = (k == 0) ? 3'h0 : (k == 1) ? 3'h3 : 3'h7;
         mode(1'b1, g);
         wr(`RBB_ADDR_INTEN, 8'h20);
         bit_tx(1, 1'b1, 1'b1);
         bit_tx(1, 1'b1, 1'b0);
         bit_tx(1, 1'b1, 1'b1);
         for (int i = 0; i < g; i++) bit_tx(1, 1'b0, 1'b0);
         `CHK("irq early", 1'b0, irq)
         bit_tx(1, 1'b0, 1'b0);
         `CHK("irq eof B", 1'b1, irq)
         rd(`RBB_ADDR_STAT);
         `CHK("stat B", 8'h30, r & 8'hF0)
         `CHK("irq rd clr", 1'b0, irq)
         rd(`RBB_ADDR_DATA_B);
         `CHK("data B", 8'h05, r)
      end
      $display("test eof done");
   endtask
   task automatic t_flow();
      mode(1'b1, 3'h3);
      wr(`RBB_ADDR_INTEN, 8'h04);
      byte_tx(0, 8'hA5);
      byte_tx(0, 8'h3C);
      `CHK("irq ovf A", 1'b1, irq)
      wr(`RBB_ADDR_INTEN, 8'h00);
      `CHK("irq masked", 1'b0, irq)
      wr(`RBB_ADDR_INTEN, 8'h01);
      `CHK("irq full A", 1'b1, irq)
      rd(`RBB_ADDR_STAT);
      `CHK("stat ovf", 8'h05, r & 8'h05)
      rd(`RBB_ADDR_DATA_A);
      `CHK("data A new", 8'h3C, r)
      wr(`RBB_ADDR_INTEN, 8'h08);
      rd(`RBB_ADDR_DATA_A);
      `CHK("irq unf A", 1'b1, irq)
      wr(`RBB_ADDR_INTEN, 8'h40);
      byte_tx(1, 8'hA5);
      byte_tx(1, 8'h3C);
      `CHK("irq ovf B", 1'b1, irq)
      rd(`RBB_ADDR_STAT);
      rd(`RBB_ADDR_DATA_B);
      wr(`RBB_ADDR_INTEN, 8'h80);
      rd(`RBB_ADDR_DATA_B);
      `CHK("irq unf B", 1'b1, irq)
      rd(`RBB_ADDR_STAT);
      `CHK("stat unf B", 8'h40, r & 8'h40)
      wr(`RBB_ADDR_INTEN, 8'h10);
      byte_tx(1, 8'hA5);
      `CHK("irq full B", 1'b1, irq)
      $display("test flow done");
   endtask
   initial begin
      i_rst_b = 1'b0;
      stb = 2'b00;
      vld = 2'b00;
      dat = 2'b00;
      repeat (6) @(posedge i_clk);
      i_rst_b <= 1'b1;
      repeat (6) @(posedge i_clk);
      t_reset();
      t_serial();
      t_byte();
      t_eof();
      t_flow();
      // Reset in mid-run with a request pending
      i_rst_b <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1'b1;
      repeat (6) @(posedge i_clk);
      t_reset();
      finish_test();
   end
endmodule // tb_rx_byte_buffer_eof_irq_ctrl
`default_nettype wire
